// ---- rtl/keyboard_link_protocol.sv ----
// What this block does
// - Half duplex: no new byte until the previous one is acknowledged.
// - Mouse data only under mouse permission or on position request, one set per permission.
// - Mouse movement keeps accumulating while reporting is not permitted.
// - Mouse position request is answered with the current accumulated counts.
// - Key code bytes are prefix plus row, then prefix plus column.
// - Every key change is reported while scanning; no rollover filtering.
// - No auto-repeat: one key-down report at the start of a press.
// - Transmissions are one or two bytes, each acknowledged by the host.
// - Only the hard-reset code may go out without a prior acknowledge.
// - Hard-reset code from the host starts the restart sequence.
// - Device requests restart with hard-reset; host replies hard-reset to command it.
// - Hard-reset sent after power-on, user reset and protocol error.
// - After sending hard-reset, any other received code causes a resend.
// - Restart clears counters, mouse on-request, scanning off, keys released, sends hard-reset.
// - Then expect first reset acknowledge and echo it, else error.
// - Then expect second reset acknowledge and echo it, else error.
// - Final acknowledge sets scan and mouse modes; anything other than a command is error.
// - LED state is kept across reset; host sets it.
// - Scanning enabled after reset only by scan-only or scan-and-mouse acknowledge.
// - Hard-reset FF, first reset acknowledge FE, second FD.
// - Final acknowledges 30 to 33, byte acknowledge 3F.
// - Key-down bytes carry prefix C, key-up bytes prefix D.
//
// Decided for this implementation: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

module keyboard_link_protocol (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic user_reset_i,
  input wire logic rx_valid_i,
  input wire logic [7:0] rx_data_i,
  output logic tx_req_o,
  output logic [7:0] tx_data_o,
  input wire logic tx_ack_i,
  input wire logic key_valid_i,
  input wire logic [3:0] key_row_i,
  input wire logic [3:0] key_col_i,
  input wire logic key_pressed_i,
  output logic key_ready_o,
  output logic scan_en_o,
  input wire logic mouse_x_step_i,
  input wire logic mouse_x_dir_i,
  input wire logic mouse_y_step_i,
  input wire logic mouse_y_dir_i,
  output logic [2:0] led_o,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [7:0] awaddr_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [7:0] araddr_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o
);

  // User reset pin synchroniser
  logic usr_s1_r, usr_s2_r, usr_s3_r, usr_lvl_r, usr_lvl_nxt, usr_evt;

  always_comb
  begin
    usr_lvl_nxt = (usr_s2_r == usr_s3_r) ? usr_s2_r : usr_lvl_r;
    usr_evt = (usr_s2_r == usr_s3_r) && usr_s2_r && !usr_lvl_r;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      usr_s1_r <= 1'b0;
      usr_s2_r <= 1'b0;
      usr_s3_r <= 1'b0;
      usr_lvl_r <= 1'b0;
    end
    else
    begin
      usr_s1_r <= user_reset_i;
      usr_s2_r <= usr_s1_r;
      usr_s3_r <= usr_s2_r;
      usr_lvl_r <= usr_lvl_nxt;
    end
  end

  // Protocol engine state
  kbd_link_pkg::link_state_type state_r, state_nxt;
  logic tx_req_r, tx_req_nxt;
  logic [7:0] tx_data_r, tx_data_nxt, hold1_r, hold1_nxt, hold2_r, hold2_nxt;
  logic scan_r, scan_nxt, permit_r, permit_nxt, request_mouse_position_cmd_r, request_mouse_position_cmd_nxt;
  logic key_ready_r, key_ready_nxt;
  logic [255:0] flags_r, flags_nxt;
  logic [6:0] x_r, x_nxt, y_r, y_nxt;
  logic [2:0] led_r, led_nxt;
  logic go_err, go_restart, cmd_ok, key_take, key_is_new, mouse_send, tx_done;
  logic soft_rst;
  logic [7:0] key_idx;

  function automatic logic [6:0] step_count(input logic [6:0] c, input logic s,
                                            input logic d);
    logic [6:0] r;
    r = c;
    if (s && !d && c != kbd_link_pkg::MOUSE_MAX)
      r = c + 7'h01;
    else if (s && d && c != kbd_link_pkg::MOUSE_MIN)
      r = c - 7'h01;
    return r;
  endfunction : step_count

  function automatic logic at_limit(input logic [6:0] c);
    return (c == kbd_link_pkg::MOUSE_MAX) || (c == kbd_link_pkg::MOUSE_MIN);
  endfunction : at_limit

  always_comb
  begin
    state_nxt = state_r;
    hold1_nxt = hold1_r;
    hold2_nxt = hold2_r;
    scan_nxt = scan_r;
    permit_nxt = permit_r;
    request_mouse_position_cmd_nxt = request_mouse_position_cmd_r;
    flags_nxt = flags_r;
    led_nxt = led_r;
    x_nxt = step_count(x_r, mouse_x_step_i, mouse_x_dir_i);
    y_nxt = step_count(y_r, mouse_y_step_i, mouse_y_dir_i);
    go_err = usr_evt || soft_rst;
    go_restart = 1'b0;
    cmd_ok = 1'b0;
    key_idx = {key_row_i, key_col_i};
    key_is_new = key_pressed_i != flags_r[key_idx];
    key_take = 1'b0;
    mouse_send = request_mouse_position_cmd_r || (permit_r && (x_r != 7'h00 || y_r != 7'h00));
    tx_done = tx_req_r && tx_ack_i;
    // Byte accepted by the framer: wait for its acknowledge
    if (tx_done)
    begin
      case (state_r)
        kbd_link_pkg::ST_ERR_SEND: state_nxt = kbd_link_pkg::ST_ERR_WAIT;
        kbd_link_pkg::ST_RST_SEND: state_nxt = kbd_link_pkg::ST_WAIT_RESET_ACK_FIRST;
        kbd_link_pkg::ST_ECHO_RESET_ACK_FIRST: state_nxt = kbd_link_pkg::ST_WAIT_RESET_ACK_SECOND;
        kbd_link_pkg::ST_ECHO_RESET_ACK_SECOND: state_nxt = kbd_link_pkg::ST_WAIT_FINAL;
        kbd_link_pkg::ST_SEND_FIRST: state_nxt = kbd_link_pkg::ST_WAIT_BYTE_ACK;
        kbd_link_pkg::ST_SEND_SECOND: state_nxt = kbd_link_pkg::ST_WAIT_FINAL;
        default: state_nxt = state_r;
      endcase
    end
    if (rx_valid_i)
    begin
      if (rx_data_i == kbd_link_pkg::CODE_HARD_RESET)
        go_restart = 1'b1;
      else
      begin
        case (state_r)
          kbd_link_pkg::ST_ERR_SEND: ;
          kbd_link_pkg::ST_ERR_WAIT: go_err = 1'b1;
          kbd_link_pkg::ST_WAIT_RESET_ACK_FIRST:
            if (rx_data_i == kbd_link_pkg::RESET_ACK_FIRST)
              state_nxt = kbd_link_pkg::ST_ECHO_RESET_ACK_FIRST;
            else
              go_err = 1'b1;
          kbd_link_pkg::ST_WAIT_RESET_ACK_SECOND:
            if (rx_data_i == kbd_link_pkg::RESET_ACK_SECOND)
              state_nxt = kbd_link_pkg::ST_ECHO_RESET_ACK_SECOND;
            else
              go_err = 1'b1;
          kbd_link_pkg::ST_RST_SEND, kbd_link_pkg::ST_ECHO_RESET_ACK_FIRST,
          kbd_link_pkg::ST_ECHO_RESET_ACK_SECOND: go_err = 1'b1;
          kbd_link_pkg::ST_WAIT_BYTE_ACK:
            if (rx_data_i == kbd_link_pkg::BYTE_ACK)
              state_nxt = kbd_link_pkg::ST_SEND_SECOND;
            else
              cmd_ok = 1'b1;
          kbd_link_pkg::ST_WAIT_FINAL:
            if (rx_data_i[7:2] == kbd_link_pkg::FINAL_ACK_PREFIX)
            begin
              scan_nxt = rx_data_i[kbd_link_pkg::ACK_SCAN_BIT];
              permit_nxt = rx_data_i[kbd_link_pkg::ACK_MOUSE_BIT];
              state_nxt = kbd_link_pkg::ST_IDLE;
            end
            else
              cmd_ok = 1'b1;
          default: cmd_ok = 1'b1;
        endcase
      end
    end
    // Commands interleave with acknowledges; anything else is an error
    if (cmd_ok)
    begin
      if (rx_data_i[7:3] == kbd_link_pkg::LED_CMD_PREFIX)
        led_nxt = rx_data_i[2:0];
      else if (rx_data_i == kbd_link_pkg::REQUEST_MOUSE_POSITION_CMD)
        request_mouse_position_cmd_nxt = 1'b1;
      else if (rx_data_i != kbd_link_pkg::CMD_NO_OP)
        go_err = 1'b1;
    end
    // Start a new report from idle
    if (state_r == kbd_link_pkg::ST_IDLE && !go_err && !go_restart)
    begin
      if (key_valid_i && key_ready_r)
      begin
        key_take = 1'b1;
        if (key_is_new)
        begin
          flags_nxt[key_idx] = key_pressed_i;
          hold1_nxt = {key_pressed_i ? kbd_link_pkg::KEY_DOWN_PREFIX
                                     : kbd_link_pkg::KEY_UP_PREFIX, key_row_i};
          hold2_nxt = {key_pressed_i ? kbd_link_pkg::KEY_DOWN_PREFIX
                                     : kbd_link_pkg::KEY_UP_PREFIX, key_col_i};
          state_nxt = kbd_link_pkg::ST_SEND_FIRST;
        end
      end
      else if (mouse_send)
      begin
        hold1_nxt = {1'b0, x_r};
        hold2_nxt = {1'b0, y_r};
        x_nxt = step_count(7'h00, mouse_x_step_i, mouse_x_dir_i);
        y_nxt = step_count(7'h00, mouse_y_step_i, mouse_y_dir_i);
        permit_nxt = 1'b0;
        request_mouse_position_cmd_nxt = cmd_ok && rx_data_i == kbd_link_pkg::REQUEST_MOUSE_POSITION_CMD;
        state_nxt = kbd_link_pkg::ST_SEND_FIRST;
      end
    end
    if (go_restart)
    begin
      state_nxt = kbd_link_pkg::ST_RST_SEND;
      x_nxt = 7'h00;
      y_nxt = 7'h00;
      permit_nxt = 1'b0;
      request_mouse_position_cmd_nxt = 1'b0;
      scan_nxt = 1'b0;
      flags_nxt = '0;
    end
    else if (go_err)
      state_nxt = kbd_link_pkg::ST_ERR_SEND;
    // Send request follows the state; data chosen on entry
    case (state_nxt)
      kbd_link_pkg::ST_ERR_SEND, kbd_link_pkg::ST_RST_SEND:
      begin
        tx_req_nxt = 1'b1;
        tx_data_nxt = kbd_link_pkg::CODE_HARD_RESET;
      end
      kbd_link_pkg::ST_ECHO_RESET_ACK_FIRST:
      begin
        tx_req_nxt = 1'b1;
        tx_data_nxt = kbd_link_pkg::RESET_ACK_FIRST;
      end
      kbd_link_pkg::ST_ECHO_RESET_ACK_SECOND:
      begin
        tx_req_nxt = 1'b1;
        tx_data_nxt = kbd_link_pkg::RESET_ACK_SECOND;
      end
      kbd_link_pkg::ST_SEND_FIRST:
      begin
        tx_req_nxt = 1'b1;
        tx_data_nxt = hold1_nxt;
      end
      kbd_link_pkg::ST_SEND_SECOND:
      begin
        tx_req_nxt = 1'b1;
        tx_data_nxt = hold2_nxt;
      end
      default:
      begin
        tx_req_nxt = 1'b0;
        tx_data_nxt = tx_data_r;
      end
    endcase
    key_ready_nxt = (state_nxt == kbd_link_pkg::ST_IDLE) && scan_nxt &&
                    !((request_mouse_position_cmd_nxt || permit_nxt) && (at_limit(x_nxt) || at_limit(y_nxt)));
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_r <= kbd_link_pkg::ST_ERR_SEND;
      tx_req_r <= 1'b0;
      tx_data_r <= kbd_link_pkg::CODE_HARD_RESET;
      hold1_r <= 8'h00;
      hold2_r <= 8'h00;
      scan_r <= 1'b0;
      permit_r <= 1'b0;
      request_mouse_position_cmd_r <= 1'b0;
      key_ready_r <= 1'b0;
      flags_r <= '0;
      x_r <= 7'h00;
      y_r <= 7'h00;
    end
    else
    begin
      state_r <= state_nxt;
      tx_req_r <= tx_req_nxt;
      tx_data_r <= tx_data_nxt;
      hold1_r <= hold1_nxt;
      hold2_r <= hold2_nxt;
      scan_r <= scan_nxt;
      permit_r <= permit_nxt;
      request_mouse_position_cmd_r <= request_mouse_position_cmd_nxt;
      key_ready_r <= key_ready_nxt;
      flags_r <= flags_nxt;
      x_r <= x_nxt;
      y_r <= y_nxt;
    end
  end

  // LEDs survive every reset
  always_ff @(posedge ref_clk_i)
  begin
    led_r <= led_nxt;
  end

  // AXI4-Lite slave
  logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
  logic [7:0] aw_addr_r, aw_addr_nxt;
  logic [31:0] w_data_r, w_data_nxt, rdata_r, rdata_nxt;
  logic [3:0] w_strb_r, w_strb_nxt;
  logic awready_r, awready_nxt, wready_r, wready_nxt, bvalid_r, bvalid_nxt;
  logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic wr_commit;

  always_comb
  begin
    aw_hold_nxt = aw_hold_r || (awvalid_i && awready_r);
    aw_addr_nxt = (awvalid_i && awready_r) ? awaddr_i : aw_addr_r;
    w_hold_nxt = w_hold_r || (wvalid_i && wready_r);
    w_data_nxt = (wvalid_i && wready_r) ? wdata_i : w_data_r;
    w_strb_nxt = (wvalid_i && wready_r) ? wstrb_i : w_strb_r;
    bvalid_nxt = bvalid_r && !bready_i;
    bresp_nxt = bresp_r;
    wr_commit = aw_hold_r && w_hold_r && !bvalid_r;
    soft_rst = wr_commit && aw_addr_r == kbd_link_pkg::REG_CTRL && w_strb_r[0] &&
               w_data_r[kbd_link_pkg::CTRL_USER_RESET_BIT];
    if (wr_commit)
    begin
      aw_hold_nxt = 1'b0;
      w_hold_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = (aw_addr_r == kbd_link_pkg::REG_CTRL) ? kbd_link_pkg::RESP_OKAY
                                                       : kbd_link_pkg::RESP_SLVERR;
    end
    awready_nxt = !aw_hold_nxt && !bvalid_nxt;
    wready_nxt = !w_hold_nxt && !bvalid_nxt;
    rvalid_nxt = rvalid_r && !rready_i;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (arvalid_i && arready_r)
    begin
      rvalid_nxt = 1'b1;
      rdata_nxt = 32'h00000000;
      rresp_nxt = kbd_link_pkg::RESP_OKAY;
      case (araddr_i)
        kbd_link_pkg::REG_CTRL: ;
        kbd_link_pkg::REG_STATUS:
        begin
          rdata_nxt[3:0] = state_r;
          rdata_nxt[kbd_link_pkg::STATUS_SCAN_BIT] = scan_r;
          rdata_nxt[kbd_link_pkg::STATUS_PERMIT_BIT] = permit_r;
          rdata_nxt[kbd_link_pkg::STATUS_REQUEST_MOUSE_POSITION_CMD_BIT] = request_mouse_position_cmd_r;
          rdata_nxt[kbd_link_pkg::STATUS_TXREQ_BIT] = tx_req_r;
        end
        kbd_link_pkg::REG_MOUSE:
        begin
          rdata_nxt[6:0] = x_r;
          rdata_nxt[kbd_link_pkg::MOUSE_Y_LSB +: 7] = y_r;
        end
        kbd_link_pkg::REG_LED: rdata_nxt[2:0] = led_r;
        default: rresp_nxt = kbd_link_pkg::RESP_SLVERR;
      endcase
    end
    arready_nxt = !rvalid_nxt;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      aw_hold_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_hold_r <= 1'b0;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= 32'h00000000;
      rresp_r <= 2'h0;
    end
    else
    begin
      aw_hold_r <= aw_hold_nxt;
      aw_addr_r <= aw_addr_nxt;
      w_hold_r <= w_hold_nxt;
      w_data_r <= w_data_nxt;
      w_strb_r <= w_strb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign tx_req_o = tx_req_r;
  assign tx_data_o = tx_data_r;
  assign key_ready_o = key_ready_r;
  assign scan_en_o = scan_r;
  assign led_o = led_r;
  assign awready_o = awready_r;
  assign wready_o = wready_r;
  assign bvalid_o = bvalid_r;
  assign bresp_o = bresp_r;
  assign arready_o = arready_r;
  assign rvalid_o = rvalid_r;
  assign rdata_o = rdata_r;
  assign rresp_o = rresp_r;

  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);

  a_tx_hold_stable: assert property (
    tx_req_o && !tx_ack_i && !rx_valid_i && !usr_evt && !soft_rst
    |=> tx_req_o && $stable(tx_data_o))
    else $error("send request dropped or data changed before acceptance");

  a_half_duplex: assert property (
    tx_req_o && tx_ack_i && !rx_valid_i && !usr_evt && !soft_rst |=> !tx_req_o)
    else $error("new byte offered before acknowledge");

  a_hard_reset_code_restart: assert property (
    rx_valid_i && rx_data_i == kbd_link_pkg::CODE_HARD_RESET
    |=> state_r == kbd_link_pkg::ST_RST_SEND && x_r == 7'h00 && !scan_en_o &&
        !permit_r && flags_r == '0 && tx_req_o && tx_data_o == 8'hFF)
    else $error("hard reset did not restart cleanly");

  a_final_modes: assert property (
    state_r == kbd_link_pkg::ST_WAIT_FINAL && rx_valid_i && !usr_evt && !soft_rst &&
    rx_data_i[7:2] == kbd_link_pkg::FINAL_ACK_PREFIX
    |=> scan_en_o == $past(rx_data_i[0]) && permit_r == $past(rx_data_i[1]) &&
        state_r == kbd_link_pkg::ST_IDLE)
    else $error("final acknowledge set wrong modes");

  a_rak_echo: assert property (
    state_r == kbd_link_pkg::ST_WAIT_RESET_ACK_FIRST && rx_valid_i && !usr_evt && !soft_rst &&
    rx_data_i == kbd_link_pkg::RESET_ACK_FIRST
    |=> tx_req_o && tx_data_o == 8'hFE)
    else $error("first reset acknowledge not echoed");

  a_reset_ack_second_error: assert property (
    state_r == kbd_link_pkg::ST_WAIT_RESET_ACK_SECOND && rx_valid_i &&
    rx_data_i != kbd_link_pkg::RESET_ACK_SECOND && rx_data_i != kbd_link_pkg::CODE_HARD_RESET
    |=> state_r == kbd_link_pkg::ST_ERR_SEND && tx_data_o == 8'hFF)
    else $error("bad second reset acknowledge not treated as error");

  a_resend_hard_reset_code: assert property (
    state_r == kbd_link_pkg::ST_ERR_WAIT && rx_valid_i &&
    rx_data_i != kbd_link_pkg::CODE_HARD_RESET
    |=> tx_req_o && tx_data_o == 8'hFF ##1 tx_data_o == 8'hFF)
    else $error("hard reset not resent");

  a_key_code: assert property (
    key_take && key_is_new
    |=> state_r == kbd_link_pkg::ST_SEND_FIRST &&
        tx_data_o == {$past(key_pressed_i) ? 4'hC : 4'hD, $past(key_row_i)} &&
        hold2_r[3:0] == $past(key_col_i))
    else $error("key code bytes malformed");

  a_no_repeat: assert property (
    key_take && !key_is_new |=> state_r == kbd_link_pkg::ST_IDLE)
    else $error("unchanged key state reported again");

  a_mouse_gate: assert property (
    state_r == kbd_link_pkg::ST_IDLE && !permit_r && !request_mouse_position_cmd_r
    |=> !(state_r == kbd_link_pkg::ST_SEND_FIRST && !tx_data_o[7]))
    else $error("mouse data sent without permission");

  a_pkt_error: assert property (
    state_r == kbd_link_pkg::ST_WAIT_BYTE_ACK && rx_valid_i &&
    rx_data_i[7:4] == 4'h3 && rx_data_i != kbd_link_pkg::BYTE_ACK
    |=> state_r == kbd_link_pkg::ST_ERR_SEND)
    else $error("unexpected acknowledge not treated as error");

  c_reset_done: cover property (
    state_r == kbd_link_pkg::ST_WAIT_FINAL ##1 state_r == kbd_link_pkg::ST_IDLE);
  c_key_packet: cover property (
    state_r == kbd_link_pkg::ST_SEND_SECOND && tx_data_o[7:4] == 4'hC && tx_ack_i);
  c_mouse_packet: cover property (
    state_r == kbd_link_pkg::ST_SEND_FIRST && !tx_data_o[7] && tx_ack_i);
  c_resend: cover property (
    state_r == kbd_link_pkg::ST_ERR_WAIT ##1 state_r == kbd_link_pkg::ST_ERR_SEND);

endmodule : keyboard_link_protocol

`default_nettype wire

// ---- rtl/kbd_link_pkg.sv ----
package kbd_link_pkg;

  // Link byte codes
  localparam logic [7:0] CODE_HARD_RESET = 8'hFF;
  localparam logic [7:0] RESET_ACK_FIRST = 8'hFE;
  localparam logic [7:0] RESET_ACK_SECOND = 8'hFD;
  localparam logic [7:0] BYTE_ACK = 8'h3F;
  localparam logic [7:0] REQUEST_MOUSE_POSITION_CMD = 8'h22;
  localparam logic [7:0] CMD_NO_OP = 8'h21;
  localparam logic [5:0] FINAL_ACK_PREFIX = 6'h0C;
  localparam int ACK_SCAN_BIT = 0;
  localparam int ACK_MOUSE_BIT = 1;
  localparam logic [4:0] LED_CMD_PREFIX = 5'h00;
  localparam logic [3:0] KEY_DOWN_PREFIX = 4'hC;
  localparam logic [3:0] KEY_UP_PREFIX = 4'hD;

  // Mouse counters, seven-bit two's complement
  localparam int MOUSE_W = 7;
  localparam logic [6:0] MOUSE_MAX = 7'h3F;
  localparam logic [6:0] MOUSE_MIN = 7'h40;

  // Register map, byte addresses
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MOUSE = 8'h08;
  localparam logic [7:0] REG_LED = 8'h0C;
  localparam int CTRL_USER_RESET_BIT = 0;
  localparam int STATUS_SCAN_BIT = 4;
  localparam int STATUS_PERMIT_BIT = 5;
  localparam int STATUS_REQUEST_MOUSE_POSITION_CMD_BIT = 6;
  localparam int STATUS_TXREQ_BIT = 7;
  localparam int MOUSE_Y_LSB = 8;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    ST_ERR_SEND = 4'h0,
    ST_ERR_WAIT = 4'h1,
    ST_RST_SEND = 4'h3,
    ST_WAIT_RESET_ACK_FIRST = 4'h2,
    ST_ECHO_RESET_ACK_FIRST = 4'h6,
    ST_WAIT_RESET_ACK_SECOND = 4'h7,
    ST_ECHO_RESET_ACK_SECOND = 4'h5,
    ST_WAIT_FINAL = 4'h4,
    ST_IDLE = 4'hC,
    ST_SEND_FIRST = 4'hD,
    ST_WAIT_BYTE_ACK = 4'hF,
    ST_SEND_SECOND = 4'hE
  } link_state_type;

endpackage : kbd_link_pkg

// ---- tb/host_link_model.sv ----
`timescale 1ns/100ps
`default_nettype none

module host_link_model (
  input wire logic ref_clk_i,
  input wire logic tx_req_i,
  input wire logic [7:0] tx_data_i,
  output logic tx_ack_o = 1'b0,
  output logic rx_valid_o = 1'b0,
  output logic [7:0] rx_data_o = 8'h00
);
  logic [7:0] got_q[$];
  logic slow = 1'b0;
  int cnt = 0;
  // Prompt and slow acceptance in turn
  always @(posedge ref_clk_i)
  begin
    tx_ack_o <= 1'b0;
    cnt <= 0;
    if (tx_req_i && tx_ack_o)
    begin
      got_q.push_back(tx_data_i);
      slow <= !slow;
    end
    else if (tx_req_i)
    begin
      cnt <= cnt + 1;
      tx_ack_o <= cnt >= (slow ? 3 : 0);
    end
  end
  // Idle data line shows the inverse of the last byte
  task automatic send(input logic [7:0] b);
    @(posedge ref_clk_i);
    rx_valid_o <= 1'b1;
    rx_data_o <= b;
    @(posedge ref_clk_i);
    rx_valid_o <= 1'b0;
    rx_data_o <= ~b;
  endtask : send
endmodule : host_link_model

`default_nettype wire

// ---- tb/tb.sv ----
`timescale 1ns/100ps
`default_nettype none

module tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic kv = 1'b0;
  logic kp = 1'b0;
  logic [3:0] kr = 4'h0;
  logic [3:0] kc = 4'h0;
  logic xs = 1'b0;
  logic xd = 1'b0;
  logic ys = 1'b0;
  logic yd = 1'b0;
  logic ur = 1'b0;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic br = 1'b0;
  logic arv = 1'b0;
  logic rr = 1'b0;
  logic [7:0] aa = 8'h00;
  logic [31:0] wd = 32'h1;
  wire logic txr, txa, rxv, kry, sen, awr, wr_o, bv, arr, rv;
  wire logic [7:0] txd, rxd;
  wire logic [2:0] led;
  wire logic [1:0] bresp, rresp;
  wire logic [31:0] rdat;
  int n_errors = 0;
  int num_checks = 0;

  keyboard_link_protocol dut_u (.ref_clk_i(clk), .rst_i(rst), .user_reset_i(ur),
    .rx_valid_i(rxv), .rx_data_i(rxd), .tx_req_o(txr), .tx_data_o(txd), .tx_ack_i(txa),
    .key_valid_i(kv), .key_row_i(kr), .key_col_i(kc), .key_pressed_i(kp), .key_ready_o(kry),
    .scan_en_o(sen), .mouse_x_step_i(xs), .mouse_x_dir_i(xd), .mouse_y_step_i(ys),
    .mouse_y_dir_i(yd), .led_o(led), .awvalid_i(awv), .awready_o(awr), .awaddr_i(aa),
    .wvalid_i(wv), .wready_o(wr_o), .wdata_i(wd), .wstrb_i(4'hF), .bvalid_o(bv),
    .bready_i(br), .bresp_o(bresp), .arvalid_i(arv), .arready_o(arr), .araddr_i(aa),
    .rvalid_o(rv), .rready_i(rr), .rdata_o(rdat), .rresp_o(rresp));
  host_link_model host_u (.ref_clk_i(clk), .tx_req_i(txr), .tx_data_i(txd), .tx_ack_o(txa),
    .rx_valid_o(rxv), .rx_data_o(rxd));

  initial
  begin
    forever #10 clk = ~clk;
  end

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e)
    begin
      $display("wrong value at %0t: got %0h expected %0h", $time, g, e);
      n_errors++;
    end
    if (e === 32'hDEAD)
      print_verdict();
  endtask : chk

  task automatic tmo(input int n);
    if (n >= 300)
      chk(32'h0, 32'hDEAD);
  endtask : tmo

  task automatic tx(input logic [7:0] e);
    int n;
    for (n = 0; n < 300 && host_u.got_q.size() == 0; n++)
      @(posedge clk);
    tmo(n);
    chk(host_u.got_q.pop_front(), e);
  endtask : tx

  task automatic none;
    repeat (30) @(posedge clk);
    chk(host_u.got_q.size(), 0);
  endtask : none

  task automatic key(input logic [3:0] r, input logic [3:0] c, input logic p);
    int n;
    @(posedge clk);
    kr <= r;
    kc <= c;
    kp <= p;
    kv <= 1'b1;
    for (n = 0; n < 300 && !(kry === 1'b1 && n > 0); n++)
      @(posedge clk);
    kv <= 1'b0;
    tmo(n);
  endtask : key

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] e,
    input logic [1:0] er);
    int n;
    @(posedge clk);
    aa <= a;
    awv <= w;
    wv <= w;
    br <= w;
    arv <= !w;
    rr <= !w;
    for (n = 0; n < 300 && !((bv === 1'b1 || rv === 1'b1) && n > 0); n++)
    begin
      @(posedge clk);
      if (awr)
        awv <= 1'b0;
      if (wr_o)
        wv <= 1'b0;
      if (arr)
        arv <= 1'b0;
    end
    br <= 1'b0;
    rr <= 1'b0;
    tmo(n);
    chk(w ? bresp : rresp, er);
    if (!w)
      chk(rdat, e);
  endtask : bus

  task automatic hs(input logic [7:0] fin);
    host_u.send(8'hFF);
    tx(8'hFF);
    host_u.send(8'hFE);
    tx(8'hFE);
    host_u.send(8'hFD);
    tx(8'hFD);
    host_u.send(fin);
    repeat (3) @(posedge clk);
    chk(sen, fin[0]);
  endtask : hs

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    tx(8'hFF);
    host_u.send(8'h21);
    tx(8'hFF);
    hs(8'h31);
    $display("test reset done");
    key(4'h2, 4'h7, 1'b1);
    tx(8'hC2);
    none();
    host_u.send(8'h3F);
    tx(8'hC7);
    host_u.send(8'h31);
    key(4'h2, 4'h7, 1'b1);
    none();
    key(4'h2, 4'h7, 1'b0);
    tx(8'hD2);
    host_u.send(8'h3F);
    tx(8'hD7);
    host_u.send(8'h31);
    $display("test keys done");
    repeat (3)
    begin
      @(posedge clk);
      xs <= 1'b1;
      @(posedge clk);
      xs <= 1'b0;
    end
    none();
    host_u.send(8'h22);
    tx(8'h03);
    host_u.send(8'h3F);
    tx(8'h00);
    host_u.send(8'h31);
    $display("test mouse done");
    key(4'h1, 4'h4, 1'b1);
    tx(8'hC1);
    host_u.send(8'h31);
    tx(8'hFF);
    hs(8'h30);
    $display("test error done");
    bus(1'b0, 8'h04, 32'h0000000C, 2'h0);
    bus(1'b0, 8'h10, 32'h0, 2'h2);
    bus(1'b1, 8'h04, 32'h0, 2'h2);
    bus(1'b1, 8'h00, 32'h0, 2'h0);
    tx(8'hFF);
    hs(8'h33);
    $display("test registers done");
    @(posedge clk);
    xs <= 1'b1;
    ys <= 1'b1;
    xd <= 1'b1;
    @(posedge clk);
    xs <= 1'b0;
    ys <= 1'b0;
    tx(8'h7F);
    host_u.send(8'h3F);
    tx(8'h01);
    host_u.send(8'h31);
    @(posedge clk);
    xs <= 1'b1;
    ys <= 1'b1;
    xd <= 1'b0;
    yd <= 1'b1;
    @(posedge clk);
    xs <= 1'b0;
    ys <= 1'b0;
    none();
    bus(1'b0, 8'h08, 32'h00007F01, 2'h0);
    host_u.send(8'h05);
    bus(1'b0, 8'h0C, 32'h00000005, 2'h0);
    $display("test mouse and led done");
    ur <= 1'b1;
    tx(8'hFF);
    ur <= 1'b0;
    hs(8'h31);
    chk(led, 32'h00000005);
    bus(1'b0, 8'h08, 32'h0, 2'h0);
    $display("test user reset done");
    print_verdict();
  end
endmodule : tb

`default_nettype wire
